// ==== rtl/opl_pkg.sv ====
// constants and types for the operator panel lock and dial control
// How it works
// [RULE1] direction 0 forward, 1 reverse, reset 0
// [RULE2] language codes 0..7, reset to 1
// [RULE3] panel select 0,1,10,11 decodes dial and lock
// [RULE4] potentiometer mode: dial updates frequency directly
// [RULE5] dial-changed frequency stored after 10 s
// [RULE6] select 10/11: hold mode 2 s locks
// [RULE7] lock shows indication; locked operations show indicator
// [RULE8] indicator returns to monitor after 2 s idle
// [RULE9] locked: hold mode 2 s releases lock
// [RULE10] locked: monitor and stop key keep working
// [RULE11] locked: key stop reset is refused
// [RULE12] panel select writable only when user group 0
// [RULE13] hold timer restarts; one toggle per hold
package opl_pkg;
	localparam int OPL_CLK_HZ = 25_000_000;
	localparam int OPL_HOLD_MS = 2000;
	localparam int OPL_STORE_MS = 10000;
	localparam int OPL_HOLD_CYC = (OPL_HOLD_MS * (OPL_CLK_HZ / 1000));
	localparam int OPL_STORE_CYC = (OPL_STORE_MS * (OPL_CLK_HZ / 1000));
	localparam int OPL_TMR_W = 28;

	localparam logic [7:0] OPL_CFG_OFS = 8'h00;
	localparam logic [7:0] OPL_UGRP_OFS = 8'h04;
	localparam logic [7:0] OPL_STAT_OFS = 8'h08;
	localparam logic [7:0] OPL_FREQ_OFS = 8'h0C;
	localparam logic [7:0] OPL_NVM_OFS = 8'h10;

	localparam int OPL_CFG_DIR_POS = 0;
	localparam int OPL_CFG_LANG_POS = 4;
	localparam int OPL_CFG_SEL_POS = 8;
	localparam int OPL_ST_LOCK_POS = 0;
	localparam int OPL_ST_DISP_POS = 1;
	localparam int OPL_ST_STOP_POS = 3;
	localparam int OPL_ST_PEND_POS = 4;
	localparam int OPL_ST_FREQ_POS = 16;

	localparam logic OPL_DIR_RST = 1'b0;
	localparam logic [2:0] OPL_LANG_RST = 3'h1;
	localparam logic [7:0] OPL_SEL_DIAL = 8'h00;
	localparam logic [7:0] OPL_SEL_POT = 8'h01;
	localparam logic [7:0] OPL_SEL_DIAL_LK = 8'h0A;
	localparam logic [7:0] OPL_SEL_POT_LK = 8'h0B;
	localparam logic [15:0] OPL_UGRP_RST = 16'h0000;
	localparam logic [15:0] OPL_FREQ_RST = 16'h0000;
	localparam logic [15:0] OPL_FREQ_MAX = 16'hFFFF;

	localparam logic [1:0] OPL_RESP_OKAY = 2'b00;
	localparam logic [1:0] OPL_RESP_SLVERR = 2'b10;

	// input pin order inside the synchroniser vector
	localparam int OPL_K_MODE = 0;
	localparam int OPL_K_STOP = 1;
	localparam int OPL_K_RUN = 2;
	localparam int OPL_K_SET = 3;
	localparam int OPL_K_RSTOP = 4;
	localparam int OPL_K_UP = 5;
	localparam int OPL_K_DN = 6;
	localparam int OPL_K_N = 7;

	typedef enum logic [1:0] {
		OPL_DISP_MON = 2'b00,
		OPL_DISP_LOCKED = 2'b01,
		OPL_DISP_ACTIVE = 2'b11
	} opl_disp_t;
endpackage

// ==== rtl/opl_panel.sv ====
// operator panel: settings, dial, key lock, stop latch, register slave
`timescale 1ns/100ps
module opl_panel import opl_pkg::*; #(
	parameter int HOLD_CYC = OPL_HOLD_CYC,
	parameter int STORE_CYC = OPL_STORE_CYC
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic mode_key_i,
	input wire logic stop_key_i,
	input wire logic run_key_i,
	input wire logic set_key_i,
	input wire logic stop_reset_key_i,
	input wire logic dial_up_i,
	input wire logic dial_down_i,
	output logic run_key_direction_select_o,
	output logic [2:0] terminal_language_select_o,
	output logic run_pulse_o,
	output logic panel_stop_o,
	output logic lock_o,
	output logic [1:0] display_o,
	output logic [15:0] set_freq_o,
	output logic nvm_write_o,
	output logic [15:0] nvm_data_o
);
	logic [OPL_K_N-1:0] sync1_reg, sync2_reg, prev_reg, press;
	logic dir_reg, nvm_we_reg, pend_reg, lock_reg, hold_done_reg;
	logic stop_reg, run_reg, aw_hold_reg, w_hold_reg, awready_reg;
	logic wready_reg, bvalid_reg, arready_reg, rvalid_reg, wr_fire;
	logic pot_mode, lock_allowed, may_set, hold_hit, locked_op, dial_move;
	logic [2:0] lang_reg;
	logic [3:0] wstrb_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [7:0] sel_reg, awaddr_reg, sel_new;
	logic [15:0] ugrp_reg, freq_reg, edit_reg, nvm_reg;
	logic [15:0] dial_next, dial_base;
	logic [31:0] wdata_reg, rdata_reg, cfg_rd, stat_rd;
	logic [31:0] cfg_new, ugrp_new, freq_new;
	logic [OPL_TMR_W-1:0] store_cnt_reg, hold_cnt_reg, idle_cnt_reg;
	opl_disp_t disp_reg;
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] mask;
		mask = {{8{strb[3]}}, {8{strb[2]}},
			{8{strb[1]}}, {8{strb[0]}}};
		return (old & ~mask) | (data & mask);
	endfunction
	// panel pins are asynchronous to the core clock
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg <= '0;
		end else begin
			sync1_reg <= {dial_down_i, dial_up_i, stop_reset_key_i,
				set_key_i, run_key_i, stop_key_i, mode_key_i};
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end
	assign press = sync2_reg & ~prev_reg;

	assign pot_mode = (sel_reg == OPL_SEL_POT) ||
		(sel_reg == OPL_SEL_POT_LK); // RULE3
	assign lock_allowed = (sel_reg == OPL_SEL_DIAL_LK) ||
		(sel_reg == OPL_SEL_POT_LK); // RULE3
	assign may_set = (ugrp_reg == 16'h0000); // RULE12
	assign hold_hit = sync2_reg[OPL_K_MODE] && !hold_done_reg &&
		(hold_cnt_reg == OPL_TMR_W'(HOLD_CYC - 1));
	// stop is deliberately not counted: it stays usable under lock
	assign locked_op = lock_reg && (press[OPL_K_RUN] || press[OPL_K_SET] ||
		press[OPL_K_RSTOP] || press[OPL_K_UP] || press[OPL_K_DN]); // RULE7
	assign dial_move = !lock_reg && (press[OPL_K_UP] ^ press[OPL_K_DN]);
	assign dial_base = pot_mode ? freq_reg : edit_reg;
	always_comb begin
		dial_next = dial_base;
		if (press[OPL_K_UP] && dial_base != OPL_FREQ_MAX) begin
			dial_next = dial_base + 16'h0001;
		end else if (press[OPL_K_DN] && dial_base != 16'h0000) begin
			dial_next = dial_base - 16'h0001;
		end
	end

	// mode key hold: restarts on release, fires once per hold
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			hold_cnt_reg <= '0;
			hold_done_reg <= 1'b0;
		end else if (!sync2_reg[OPL_K_MODE]) begin
			hold_cnt_reg <= '0; // RULE13
			hold_done_reg <= 1'b0; // RULE13
		end else if (hold_hit) begin
			hold_done_reg <= 1'b1; // RULE13
		end else if (!hold_done_reg) begin
			hold_cnt_reg <= hold_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			lock_reg <= 1'b0;
		end else if (lock_reg && (hold_hit || !lock_allowed)) begin
			lock_reg <= 1'b0; // RULE9
		end else if (!lock_reg && hold_hit && lock_allowed) begin
			lock_reg <= 1'b1; // RULE6
		end
	end

	// monitor stays the base view; lock views time out
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			disp_reg <= OPL_DISP_MON;
			idle_cnt_reg <= '0;
		end else begin
			case (disp_reg)
			OPL_DISP_MON: begin
				idle_cnt_reg <= '0;
				if (!lock_reg && hold_hit && lock_allowed) begin
					disp_reg <= OPL_DISP_LOCKED; // RULE7
				end else if (locked_op) begin
					disp_reg <= OPL_DISP_ACTIVE; // RULE7
				end
			end
			default: begin
				if (!lock_reg || hold_hit) begin
					disp_reg <= OPL_DISP_MON;
					idle_cnt_reg <= '0;
				end else if (locked_op) begin
					disp_reg <= OPL_DISP_ACTIVE; // RULE7
					idle_cnt_reg <= '0; // RULE8
				end else if (idle_cnt_reg == OPL_TMR_W'(HOLD_CYC - 1)) begin
					disp_reg <= OPL_DISP_MON; // RULE8
					idle_cnt_reg <= '0;
				end else begin
					idle_cnt_reg <= idle_cnt_reg + 1'b1;
				end
			end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			stop_reg <= 1'b0;
			run_reg <= 1'b0;
		end else begin
			if (press[OPL_K_STOP]) begin
				stop_reg <= 1'b1; // RULE10
			end else if (press[OPL_K_RSTOP] && !lock_reg) begin
				stop_reg <= 1'b0; // RULE11
			end
			run_reg <= press[OPL_K_RUN] && !lock_reg && !stop_reg;
		end
	end

	// frequency: dial edits, bus can also load the set value
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			freq_reg <= OPL_FREQ_RST;
			edit_reg <= OPL_FREQ_RST;
		end else if (dial_move && pot_mode) begin
			freq_reg <= dial_next; // RULE4
			edit_reg <= dial_next;
		end else if (dial_move) begin
			edit_reg <= dial_next;
		end else if (press[OPL_K_SET] && !lock_reg && !pot_mode) begin
			freq_reg <= edit_reg;
		end else if (wr_fire && awaddr_reg == OPL_FREQ_OFS && may_set) begin
			freq_reg <= freq_new[15:0];
			edit_reg <= freq_new[15:0];
		end
	end

	// each pot-mode dial change or unlocked dial-mode set key press restarts the store delay, saving wear
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			pend_reg <= 1'b0;
			store_cnt_reg <= '0;
			nvm_we_reg <= 1'b0;
			nvm_reg <= OPL_FREQ_RST;
		end else begin
			nvm_we_reg <= 1'b0;
			if ((dial_move && pot_mode) ||
				(press[OPL_K_SET] && !lock_reg && !pot_mode)) begin
				pend_reg <= 1'b1; // RULE5
				store_cnt_reg <= '0;
			end else if (pend_reg &&
				store_cnt_reg == OPL_TMR_W'(STORE_CYC - 1)) begin
				pend_reg <= 1'b0; // RULE5
				nvm_we_reg <= 1'b1;
				nvm_reg <= freq_reg;
			end else if (pend_reg) begin
				store_cnt_reg <= store_cnt_reg + 1'b1;
			end
		end
	end

	assign cfg_rd = {16'h0000, sel_reg, 1'b0, lang_reg, 3'b000, dir_reg};
	assign stat_rd = {freq_reg, 11'h000, pend_reg, stop_reg,
		disp_reg, lock_reg};
	assign cfg_new = merge(cfg_rd, wdata_reg, wstrb_reg);
	assign ugrp_new = merge({16'h0000, ugrp_reg}, wdata_reg, wstrb_reg);
	assign freq_new = merge({16'h0000, freq_reg}, wdata_reg, wstrb_reg);
	assign sel_new = cfg_new[OPL_CFG_SEL_POS +: 8];
	assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			dir_reg <= OPL_DIR_RST; // RULE1
			lang_reg <= OPL_LANG_RST; // RULE2
			sel_reg <= OPL_SEL_DIAL; // RULE3
			ugrp_reg <= OPL_UGRP_RST;
		end else if (wr_fire) begin
			if (awaddr_reg == OPL_CFG_OFS && may_set) begin
				dir_reg <= cfg_new[OPL_CFG_DIR_POS]; // RULE1
				lang_reg <= cfg_new[OPL_CFG_LANG_POS +: 3]; // RULE2
				if (sel_new == OPL_SEL_DIAL || sel_new == OPL_SEL_POT ||
					sel_new == OPL_SEL_DIAL_LK ||
					sel_new == OPL_SEL_POT_LK) begin
					sel_reg <= sel_new; // RULE12
				end
			end else if (awaddr_reg == OPL_UGRP_OFS) begin
				ugrp_reg <= ugrp_new[15:0];
			end
		end
	end

	// write side: address and data taken in either order
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= OPL_RESP_OKAY;
		end else begin
			awready_reg <= !aw_hold_reg && !bvalid_reg &&
				!(s_axi_awvalid && awready_reg);
			wready_reg <= !w_hold_reg && !bvalid_reg &&
				!(s_axi_wvalid && wready_reg);
			if (s_axi_awvalid && awready_reg) begin
				aw_hold_reg <= 1'b1;
				awaddr_reg <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && wready_reg) begin
				w_hold_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				if (awaddr_reg == OPL_CFG_OFS || awaddr_reg == OPL_UGRP_OFS ||
					awaddr_reg == OPL_FREQ_OFS) begin
					bresp_reg <= OPL_RESP_OKAY;
				end else begin
					bresp_reg <= OPL_RESP_SLVERR;
				end
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= OPL_RESP_OKAY;
		end else begin
			arready_reg <= !rvalid_reg && !(s_axi_arvalid && arready_reg);
			if (s_axi_arvalid && arready_reg) begin
				rvalid_reg <= 1'b1;
				rresp_reg <= OPL_RESP_OKAY;
				if (s_axi_araddr[7:2] == OPL_CFG_OFS[7:2]) begin
					rdata_reg <= cfg_rd;
				end else if (s_axi_araddr[7:2] == OPL_UGRP_OFS[7:2]) begin
					rdata_reg <= {16'h0000, ugrp_reg};
				end else if (s_axi_araddr[7:2] == OPL_STAT_OFS[7:2]) begin
					rdata_reg <= stat_rd;
				end else if (s_axi_araddr[7:2] == OPL_FREQ_OFS[7:2]) begin
					rdata_reg <= {16'h0000, freq_reg};
				end else if (s_axi_araddr[7:2] == OPL_NVM_OFS[7:2]) begin
					rdata_reg <= {16'h0000, nvm_reg};
				end else begin
					rdata_reg <= 32'h0000_0000;
					rresp_reg <= OPL_RESP_SLVERR;
				end
			end else if (rvalid_reg && s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign run_key_direction_select_o = dir_reg; // RULE1
	assign terminal_language_select_o = lang_reg;
	assign run_pulse_o = run_reg;
	assign panel_stop_o = stop_reg;
	assign lock_o = lock_reg;
	assign display_o = disp_reg;
	assign set_freq_o = freq_reg;
	assign nvm_write_o = nvm_we_reg;
	assign nvm_data_o = nvm_reg;
endmodule

// ==== bench/opl_panel_checker.sv ====
// port assertions for the operator panel
`timescale 1ns/100ps
module opl_panel_checker import opl_pkg::*; #(
	parameter int HOLD_CYC = 20,
	parameter int STORE_CYC = 50
) (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic mode_key_i,
	input wire logic stop_key_i,
	input wire logic run_key_i,
	input wire logic set_key_i,
	input wire logic stop_reset_key_i,
	input wire logic dial_up_i,
	input wire logic dial_down_i,
	input wire logic run_pulse_o,
	input wire logic panel_stop_o,
	input wire logic lock_o,
	input wire logic [1:0] display_o,
	input wire logic [15:0] set_freq_o,
	input wire logic nvm_write_o,
	input wire logic [15:0] nvm_data_o
);
	logic [31:0] idle_reg;
	logic [1:0] disp_reg;
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	// age of an unchanged lock view; a held operation key restarts it
	always_ff @(posedge clock_i) begin
		disp_reg <= display_o;
		if (rst_i || display_o == OPL_DISP_MON || display_o != disp_reg ||
			run_key_i || set_key_i || stop_reset_key_i || dial_up_i ||
			dial_down_i) begin
			idle_reg <= 32'h0000_0000;
		end else begin
			idle_reg <= idle_reg + 32'h0000_0001;
		end
	end
	a_lock_cause: assert property (
		$rose(lock_o) |-> $past(mode_key_i, 5))
		else $error("lock engaged without a mode key hold");
	a_lock_view: assert property (
		$rose(lock_o) |-> ##[0:1] display_o == OPL_DISP_LOCKED)
		else $error("lock engaged without lock view");
	a_run_locked: assert property (
		lock_o && $past(lock_o) |-> !run_pulse_o)
		else $error("run pulse while locked");
	a_view_timeout: assert property (
		idle_reg <= HOLD_CYC + 2)
		else $error("lock view stood too long");
	a_unlock_view: assert property (
		!lock_o && !$past(lock_o) |-> display_o == OPL_DISP_MON)
		else $error("lock view while unlocked");
	a_stop_key: assert property (
		$rose(stop_key_i) |-> ##[1:6] panel_stop_o)
		else $error("stop key not obeyed");
	a_stop_kept: assert property (
		lock_o && panel_stop_o |=> panel_stop_o)
		else $error("stop cleared while locked");
	a_store_data: assert property (
		nvm_write_o |-> nvm_data_o == set_freq_o)
		else $error("stored value differs from set frequency");
endmodule
bind opl_panel opl_panel_checker #(
	.HOLD_CYC(HOLD_CYC), .STORE_CYC(STORE_CYC)
) u_checker (
	.clock_i(clock_i), .rst_i(rst_i), .mode_key_i(mode_key_i),
	.stop_key_i(stop_key_i), .run_key_i(run_key_i),
	.set_key_i(set_key_i), .stop_reset_key_i(stop_reset_key_i),
	.dial_up_i(dial_up_i), .dial_down_i(dial_down_i),
	.run_pulse_o(run_pulse_o),
	.panel_stop_o(panel_stop_o), .lock_o(lock_o), .display_o(display_o),
	.set_freq_o(set_freq_o), .nvm_write_o(nvm_write_o),
	.nvm_data_o(nvm_data_o)
);

// ==== bench/opl_operator.sv ====
// operator at the panel: drives key and dial pins
`timescale 1ns/100ps
module opl_operator import opl_pkg::*; (
	input wire logic clock_i,
	input wire logic [6:0] want_i,
	input wire logic lock_i,
	input wire logic rude_i,
	output logic [6:0] pins_o
);
	// a polite operator holds back the stop reset key while the lock is on
	always @(posedge clock_i) begin
		pins_o <= want_i & ~({6'h00, lock_i && !rude_i} << OPL_K_RSTOP);
	end
endmodule

// ==== bench/opl_panel_test.sv ====
// self-checking bench for the operator panel
`timescale 1ns/100ps
module opl_panel_test;
	import opl_pkg::*;
	localparam int HC = 20;
	localparam int SC = 50;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, rude = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, run_p, stop_q, lock;
	logic [1:0] bresp, rresp, disp;
	logic [6:0] want = 7'h00, pins;
	logic dir, nvw;
	logic [2:0] lang;
	logic [15:0] freq, nvd;
	int n_mismatch = 0, samples_checked = 0, n_run = 0, n_store = 0;
	logic [1:0] bq[$];
	logic [65:0] rq[$];
	logic [31:0] seed = 32'h0000_0D92;
	logic [7:0] sel[4] = '{OPL_SEL_DIAL, OPL_SEL_POT, OPL_SEL_DIAL_LK,
		OPL_SEL_POT_LK};
	always #20 clock_i = ~clock_i;
	opl_panel #(.HOLD_CYC(HC), .STORE_CYC(SC)) dut (
		.clock_i(clock_i), .rst_i(rst_i), .s_axi_awaddr(awaddr),
		.s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.mode_key_i(pins[0]), .stop_key_i(pins[1]), .run_key_i(pins[2]),
		.set_key_i(pins[3]), .stop_reset_key_i(pins[4]), .dial_up_i(pins[5]),
		.dial_down_i(pins[6]), .run_key_direction_select_o(dir),
		.terminal_language_select_o(lang), .run_pulse_o(run_p),
		.panel_stop_o(stop_q), .lock_o(lock), .display_o(disp),
		.set_freq_o(freq), .nvm_write_o(nvw), .nvm_data_o(nvd));
	opl_operator op (.clock_i(clock_i), .want_i(want), .lock_i(lock),
		.rude_i(rude), .pins_o(pins));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] s, e, input string n);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// address and data stay up until each is taken on its own
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = OPL_RESP_OKAY);
		bit ad, wd;
		ad = 1'b0;
		wd = 1'b0;
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ad && wd)) begin
			@(negedge clock_i);
			ad = ad | awready;
			wd = wd | wready;
			@(posedge clock_i);
			if (ad) awvalid <= 1'b0;
			if (wd) wvalid <= 1'b0;
		end
		do @(negedge clock_i); while (!bvalid);
		@(posedge clock_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFF_FFFF,
		input logic [1:0] r = OPL_RESP_OKAY);
		rq.push_back({r, m, e});
		araddr <= a;
		arvalid <= 1'b1;
		do @(negedge clock_i); while (!arready);
		@(posedge clock_i);
		arvalid <= 1'b0;
		do @(negedge clock_i); while (!rvalid);
		@(posedge clock_i);
	endtask
	task automatic key(input int k, input int n);
		want[k] <= 1'b1;
		repeat (n) @(posedge clock_i);
		want[k] <= 1'b0;
		repeat (8) @(posedge clock_i);
	endtask
	always @(negedge clock_i) begin
		logic [65:0] q;
		if (bvalid)
			chk(bresp, bq.pop_front(), "bresp");
		if (rvalid) begin
			q = rq.pop_front();
			chk(rresp, q[65:64], "rresp");
			chk(rdata & q[63:32], q[31:0], "rdata");
		end
		if (run_p)
			n_run++;
		if (nvw)
			n_store++;
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		n_mismatch++;
		test_done();
	end
	initial begin
		logic [31:0] r, c;
		logic [15:0] f;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		@(posedge clock_i);
		rd(OPL_CFG_OFS, 32'h0000_0010);
		rd(OPL_STAT_OFS, 32'h0000_0000);
		rd(8'h14, 32'h0000_0000, 32'hFFFF_FFFF, OPL_RESP_SLVERR);
		wr(8'h14, 32'h0000_0001, OPL_RESP_SLVERR);
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			r = xs();
			c = {16'h0000, sel[i % 4], 1'b0, 3'(i), 3'h0, r[0]};
			wr(OPL_CFG_OFS, c);
			rd(OPL_CFG_OFS, c);
			chk(dir, r[0], "dir");
			chk(lang, i, "lang");
		end
		wr(OPL_CFG_OFS, 32'h0000_0520);
		rd(OPL_CFG_OFS, 32'h0000_0B20);
		wr(OPL_UGRP_OFS, 32'h0000_0001);
		wr(OPL_CFG_OFS, 32'h0000_0011);
		rd(OPL_CFG_OFS, 32'h0000_0B20);
		wr(OPL_UGRP_OFS, 32'h0000_0000);
		$display("setting test done");
		wr(OPL_CFG_OFS, 32'h0000_0110);
		r = xs();
		f = {2'b00, r[13:0]};
		wr(OPL_FREQ_OFS, {16'h0000, f});
		repeat (3) key(5, 2);
		key(6, 2);
		rd(OPL_STAT_OFS, {f + 16'h0002, 16'h0000}, 32'hFFFF_0000);
		chk(freq, f + 16'h0002, "freq");
		rd(OPL_NVM_OFS, 32'h0000_0000, 32'h0000_FFFF);
		repeat (SC + 10) @(posedge clock_i);
		rd(OPL_NVM_OFS, {16'h0000, f + 16'h0002}, 32'h0000_FFFF);
		chk(nvd, f + 16'h0002, "nvm data");
		chk(n_store, 1, "stores");
		wr(OPL_CFG_OFS, 32'h0000_0010);
		key(5, 2);
		rd(OPL_STAT_OFS, {f + 16'h0002, 16'h0000}, 32'hFFFF_0000);
		key(3, 2);
		rd(OPL_STAT_OFS, {f + 16'h0003, 16'h0010}, 32'hFFFF_0010);
		$display("dial test done");
		key(0, 30);
		rd(OPL_STAT_OFS, 32'h0000_0000, 32'h0000_000F);
		wr(OPL_CFG_OFS, 32'h0000_0B10);
		key(0, 10);
		rd(OPL_STAT_OFS, 32'h0000_0000, 32'h0000_000F);
		key(0, 50);
		rd(OPL_STAT_OFS, 32'h0000_0001, 32'h0000_000F);
		chk(lock, 1, "lock");
		key(5, 2);
		rd(OPL_STAT_OFS, {f + 16'h0003, 16'h0007}, 32'hFFFF_000F);
		chk(disp, OPL_DISP_ACTIVE, "display");
		key(2, 2);
		chk(n_run, 0, "run");
		key(1, 2);
		rd(OPL_STAT_OFS, 32'h0000_0009, 32'h0000_0009);
		chk(stop_q, 1, "stop");
		rude <= 1'b1;
		key(4, 2);
		rude <= 1'b0;
		rd(OPL_STAT_OFS, 32'h0000_0009, 32'h0000_0009);
		key(0, 26);
		rd(OPL_STAT_OFS, 32'h0000_0000, 32'h0000_0001);
		key(4, 2);
		rd(OPL_STAT_OFS, 32'h0000_0000, 32'h0000_0008);
		key(2, 2);
		chk(n_run, 1, "run");
		chk(nvd, f + 16'h0003, "nvm data");
		chk(n_store, 2, "stores");
		$display("lock test done");
		test_done();
	end
endmodule
